// file: tb/scrc_assertions.sv
`timescale 1ns/100ps
// ------------------------------------------
// port level checks of scrc_top
// ------------------------------------------
module scrc_sva
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       por_rst,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       main_osc_fail,
	input wire logic       main_osc_stable,
	input wire logic       current_limit_evt,
	input wire logic       unregulated_evt,
	input wire logic       pll_locked,
	input wire logic       deep_sleep_req,
	input wire logic       irq,
	input wire logic       sys_reset_req,
	input wire logic       core_run_en,
	input wire logic [1:0] clk_sel,
	input wire logic       pll_power_down
);
	// anything that may lift the interrupt; masks are not visible here
	wire logic cause = avs_write | main_osc_fail | current_limit_evt | unregulated_evt | pll_locked;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst || por_rst);
	a_reset_pll_down: assert property (
		$past(sys_rst) || $past(por_rst) |-> pll_power_down && !irq && !sys_reset_req)
		else $error("pll not powered down after reset");
	a_unreg_reset_cause: assert property (
		sys_reset_req |-> $past(unregulated_evt)) else $error("reset request without cause");
	a_bus_answer_next: assert property (
		$rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("bus answer late");
	a_bus_answer_once: assert property (
		!avs_waitrequest |=> avs_waitrequest) else $error("bus answer too long");
	a_irq_rise_cause: assert property (
		$rose(irq) |-> $past(cause, 2) || $past(cause, 3)) else $error("irq without cause");
	a_irq_fall_write: assert property (
		$fell(irq) |-> $past(avs_write, 2)) else $error("irq dropped without write");
	a_core_halt_sleep: assert property (
		$fell(core_run_en) |-> $past(deep_sleep_req) || $past(deep_sleep_req, 2))
		else $error("core halted without sleep request");
	a_core_wait_osc: assert property (
		$rose(core_run_en) && clk_sel == 2'h0 |-> $past(main_osc_stable) || $past(pll_locked))
		else $error("core ran before oscillator stable");
	cover property ($rose(irq));
	cover property ($rose(sys_reset_req));
	cover property ($fell(core_run_en));
endmodule
bind scrc_top scrc_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.main_osc_fail(main_osc_fail), .main_osc_stable(main_osc_stable),
	.current_limit_evt(current_limit_evt), .unregulated_evt(unregulated_evt),
	.pll_locked(pll_locked), .deep_sleep_req(deep_sleep_req), .irq(irq),
	.sys_reset_req(sys_reset_req), .core_run_en(core_run_en), .clk_sel(clk_sel),
	.pll_power_down(pll_power_down));

// file: tb/system_clock_reset_control_test.sv
`timescale 1ns/100ps
module system_clock_reset_control_test;
	logic sys_clk = 1'b0, sys_rst = 1'b1, por_rst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
	logic avs_waitrequest, irq, sys_reset_req, core_run_en, pll_power_down;
	logic main_osc_fail = 1'b0, main_osc_stable = 1'b0, current_limit_evt = 1'b0;
	logic unregulated_evt = 1'b0, pll_locked = 1'b0, deep_sleep_req = 1'b0, wake_evt = 1'b0;
	logic [1:0] clk_sel;
	logic [4:0] pll_prediv;
	logic [8:0] pll_mult;
	logic [2:0] regulator_vadj;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	// rows: crystal code beside the translation it must give
	logic [3:0] code [5] = '{4'h6, 4'h9, 4'hB, 4'hE, 4'hF};
	logic [13:0] trans [5] = '{14'h0264, 14'h0B90, 14'h06C8, 14'h0464, 14'h0AC8};
	scrc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .main_osc_fail(main_osc_fail),
		.main_osc_stable(main_osc_stable), .current_limit_evt(current_limit_evt),
		.unregulated_evt(unregulated_evt), .pll_locked(pll_locked),
		.deep_sleep_req(deep_sleep_req), .wake_evt(wake_evt), .irq(irq),
		.sys_reset_req(sys_reset_req), .core_run_en(core_run_en), .clk_sel(clk_sel),
		.pll_power_down(pll_power_down), .pll_prediv(pll_prediv), .pll_mult(pll_mult),
		.regulator_vadj(regulator_vadj));
	always #5 sys_clk = ~sys_clk;
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		tk(1);
		while (avs_waitrequest !== 1'b0)
			tk(1);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		tk(1);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_rst(input logic p);
		sys_rst <= !p;
		por_rst <= p;
		tk(2);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		tk(1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog, far above the roughly 180 cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			test_done;
		end
	end
	initial
	begin
		do_rst(1'b1);
		bus(6'h00, 1'b0, 32'h0); chk(rdat, 32'hB6);
		bus(6'h14, 1'b0, 32'h0); chk(rdat, 32'h06C8);
		bus(6'h3C, 1'b0, 32'h0); chk(rdat, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			bus(6'h00, 1'b1, {24'h0, code[i], 4'h6});
			bus(6'h14, 1'b0, 32'h0); chk(rdat, {18'h0, trans[i]});
			chk({18'h0, pll_prediv, pll_mult}, {18'h0, trans[i]});
		end
		do_rst(1'b0);
		bus(6'h00, 1'b0, 32'h0); chk(rdat, 32'hB6);
		bus(6'h14, 1'b0, 32'h0); chk(rdat, 32'h06C8);
		$display("test crystal done");
		bus(6'h08, 1'b1, 32'h0);
		{current_limit_evt, unregulated_evt, pll_locked} <= 3'h7;
		tk(1);
		{current_limit_evt, unregulated_evt, pll_locked} <= 3'h0;
		tk(2);
		bus(6'h04, 1'b0, 32'h0); chk(rdat, 32'h6);
		chk(32'(irq), 32'h0);
		bus(6'h08, 1'b1, 32'h2); tk(1); chk(32'(irq), 32'h1);
		bus(6'h04, 1'b1, 32'h2);
		bus(6'h08, 1'b1, 32'h4); tk(1); chk(32'(irq), 32'h1);
		bus(6'h08, 1'b1, 32'h0); tk(1); chk(32'(irq), 32'h0);
		bus(6'h1C, 1'b1, 32'h1);
		unregulated_evt <= 1'b1;
		tk(2); chk(32'(sys_reset_req), 32'h1);
		unregulated_evt <= 1'b0;
		tk(2); chk(32'(sys_reset_req), 32'h0);
		bus(6'h04, 1'b1, 32'hF);
		bus(6'h18, 1'b1, 32'h1);
		chk(32'(regulator_vadj), 32'h1);
		bus(6'h00, 1'b1, 32'hB2); chk(32'(pll_power_down), 32'h0);
		pll_locked <= 1'b1;
		tk(2);
		pll_locked <= 1'b0;
		bus(6'h04, 1'b0, 32'h0); chk(rdat, 32'h8);
		chk(32'(irq), 32'h0);
		bus(6'h08, 1'b1, 32'h8);
		tk(1);
		chk(32'(irq), 32'h1);
		$display("test events done");
		bus(6'h04, 1'b1, 32'hF);
		bus(6'h08, 1'b1, 32'h1);
		bus(6'h00, 1'b1, 32'hB7);
		main_osc_fail <= 1'b1;
		tk(4); chk({30'h0, clk_sel}, 32'h1);
		chk(32'(irq), 32'h1);
		main_osc_fail <= 1'b0;
		do_rst(1'b0);
		$display("test failover done");
		for (int s = 1; s < 4; s++)
		begin
			bus(6'h10, 1'b1, 32'(s));
			deep_sleep_req <= 1'b1;
			tk(1);
			deep_sleep_req <= 1'b0;
			tk(2); chk({29'h0, core_run_en, clk_sel}, 32'(s));
			wake_evt <= 1'b1;
			tk(1);
			wake_evt <= 1'b0;
			tk(4); chk(32'(core_run_en), 32'h0);
			main_osc_stable <= 1'b1;
			tk(4); chk({29'h0, core_run_en, clk_sel}, 32'h4);
			main_osc_stable <= 1'b0;
		end
		bus(6'h18, 1'b1, 32'h1);
		bus(6'h00, 1'b1, 32'hB0);
		deep_sleep_req <= 1'b1;
		tk(1);
		deep_sleep_req <= 1'b0;
		wake_evt <= 1'b1;
		tk(1);
		wake_evt <= 1'b0;
		main_osc_stable <= 1'b1;
		tk(4);
		chk(32'(core_run_en), 32'h0);
		pll_locked <= 1'b1;
		tk(4);
		chk({29'h0, core_run_en, clk_sel}, 32'h4);
		{pll_locked, main_osc_stable} <= 2'h0;
		$display("test wake done");
		test_done;
	end
endmodule

// file: verilog/scrc_pkg.sv
package scrc_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses on the avalon slave
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] ADDR_RUN_CLOCK_CONFIG         = 6'h00;
	localparam logic [5:0] ADDR_RAW_STATUS               = 6'h04;
	localparam logic [5:0] ADDR_INTERRUPT_MASK_CONTROL   = 6'h08;
	localparam logic [5:0] ADDR_MASKED_STATUS            = 6'h0C;
	localparam logic [5:0] ADDR_DEEP_SLEEP_CLOCK_CONFIG  = 6'h10;
	localparam logic [5:0] ADDR_CRYSTAL_TO_PLL_TRANS     = 6'h14;
	localparam logic [5:0] ADDR_REGULATOR_POWER_CONTROL  = 6'h18;
	localparam logic [5:0] ADDR_UNREGULATED_RESET_ALLOW  = 6'h1C;
	localparam logic [5:0] ADDR_SYSTEM_STATUS            = 6'h20;

	// ----------------------------------------------------------------
	// run clock config fields
	// ----------------------------------------------------------------
	localparam int RCC_W               = 8;
	localparam int RCC_VERIFY_BIT      = 0;   // main_osc_verify_enable
	localparam int RCC_PLL_BYPASS_BIT  = 1;   // core bypasses the pll
	localparam int RCC_PLL_PLL_POWER_DOWN_BIT   = 2;   // pll_power_down
	localparam int RCC_RUN_INT_BIT     = 3;   // run from internal 12 mhz osc
	localparam int RCC_CRYSTAL_FREQ_SELECT_LSB        = 4;   // crystal_freq_select
	localparam int CRYSTAL_FREQ_SELECT_W              = 4;

	// crystal codes (encoding is local to this block)
	localparam logic [3:0] CRYSTAL_FREQ_SELECT_4MHZ  = 4'h6;
	localparam logic [3:0] CRYSTAL_FREQ_SELECT_5MHZ  = 4'h9;
	localparam logic [3:0] CRYSTAL_FREQ_SELECT_6MHZ  = 4'hB;
	localparam logic [3:0] CRYSTAL_FREQ_SELECT_8MHZ  = 4'hE;
	localparam logic [3:0] CRYSTAL_FREQ_SELECT_10MHZ = 4'hF;

	// pll comes up powered down, crystal at 6 mhz, bypassed
	localparam logic [7:0] RCC_RESET  = 8'hB6;

	// ----------------------------------------------------------------
	// crystal to pll translation: {prediv, mult}, out = crystal mhz/prediv*mult
	// ----------------------------------------------------------------
	localparam int PREDIV_W = 5;
	localparam int MULT_W   = 9;
	localparam int TRANS_W  = 14;
	localparam logic [13:0] TRANS_4MHZ  = 14'h0264;  // 4/1*100  = 400
	localparam logic [13:0] TRANS_5MHZ  = 14'h0B90;  // 5/5*400  = 400
	localparam logic [13:0] TRANS_6MHZ  = 14'h06C8;  // 6/3*200  = 400
	localparam logic [13:0] TRANS_8MHZ  = 14'h0464;  // 8/2*100  = 400
	localparam logic [13:0] TRANS_10MHZ = 14'h0AC8;  // 10/5*200 = 400

	// ----------------------------------------------------------------
	// event bits, shared by raw status, mask and masked status
	// ----------------------------------------------------------------
	localparam int EVT_W             = 4;
	localparam int EVT_OSC_FAIL      = 0;
	localparam int EVT_CURRENT_LIMIT = 1;
	localparam int EVT_UNREGULATED   = 2;
	localparam int EVT_PLL_LOCK      = 3;
	localparam logic [3:0] IMC_RESET = 4'h1;   // oscillator failure unmasked

	// ----------------------------------------------------------------
	// clock source codes, used for deep sleep field and clock select
	// ----------------------------------------------------------------
	localparam int CLK_W = 2;
	localparam logic [1:0] CLK_MAIN_OSC = 2'h0;
	localparam logic [1:0] CLK_INT_12M  = 2'h1;
	localparam logic [1:0] CLK_INT_30K  = 2'h2;
	localparam logic [1:0] CLK_EXT_32K  = 2'h3;

	// regulator output adjust, zero is the 2.5 v default
	localparam int VADJ_W = 3;
	localparam logic [2:0] VADJ_RESET = 3'h0;

	// ----------------------------------------------------------------
	// wake sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		WAKE_RUN      = 4'b0001,
		WAKE_SLEEP    = 4'b0010,
		WAKE_WAIT_OSC = 4'b0100,
		WAKE_WAIT_PLL = 4'b1000
	} scrc_wake_state_type;

	// crystal code to pll translation, unknown codes fall back to 6 mhz
	function automatic logic [13:0] crystal_freq_select_to_trans(input logic [3:0] code);
		logic [13:0] t;
		t = TRANS_6MHZ;
		case (code)
			CRYSTAL_FREQ_SELECT_4MHZ:  t = TRANS_4MHZ;
			CRYSTAL_FREQ_SELECT_5MHZ:  t = TRANS_5MHZ;
			CRYSTAL_FREQ_SELECT_6MHZ:  t = TRANS_6MHZ;
			CRYSTAL_FREQ_SELECT_8MHZ:  t = TRANS_8MHZ;
			CRYSTAL_FREQ_SELECT_10MHZ: t = TRANS_10MHZ;
			default:    t = TRANS_6MHZ;
		endcase
		return t;
	endfunction

endpackage

// file: verilog/scrc_top.sv
`timescale 1ns/100ps
module scrc_top
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        por_rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        main_osc_fail,
	input  wire logic        main_osc_stable,
	input  wire logic        current_limit_evt,
	input  wire logic        unregulated_evt,
	input  wire logic        pll_locked,
	input  wire logic        deep_sleep_req,
	input  wire logic        wake_evt,
	output logic             irq,
	output logic             sys_reset_req,
	output logic             core_run_en,
	output logic      [1:0]  clk_sel,
	output logic             pll_power_down,
	output logic      [4:0]  pll_prediv,
	output logic      [8:0]  pll_mult,
	output logic      [2:0]  regulator_vadj
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                          rst_any;          // either reset source
	logic                          ack_ff;           // answer phase, waitrequest low
	logic [31:0]                   rdata_ff;         // registered read data
	logic [31:0]                   rd_word;          // read mux output
	logic                          wr_go;            // write takes effect now
	logic                          rd_go;            // read data captured now
	logic [7:0]                    run_clock_config_ff;       // run mode clock setup
	logic [13:0]                   trans_ff;                  // crystal_to_pll_translation
	logic [3:0]                    raw_ff;                    // sticky raw event flags
	logic [3:0]                    interrupt_mask_control_ff; // event masks
	logic [1:0]                    deep_sleep_clock_config_ff;// deep sleep source
	logic [2:0]                    regulator_power_control_ff;// regulator adjust
	logic                          unregulated_reset_allow_ff;// reset on unregulated
	logic [3:0]                    evt_set;          // events seen this cycle
	logic [3:0]                    evt_clr;          // write-one-to-clear bits
	logic [3:0]                    nxt_raw;          // raw flags after set and clear
	logic                          pll_locked_q_ff;  // lock input one cycle ago
	logic                          failover_ff;      // oscillator declared failed
	logic                          irq_ff;           // registered interrupt
	logic                          reset_req_ff;     // registered reset request
	logic [7:0]                    rcc_wr;           // merged run clock write value

	// config and status bundle for the sequencer
	scrc_wake_if wk ();

	// both reset sources clear the block; power-on is not special here
	assign rst_any = sys_rst | por_rst;

	// ----------------------------------------------------------------
	// helper: merge write data into a register by byte enables
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_merge
	(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		end
		return res;
	endfunction

	// address match, shared by read and write decode
	function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_addr);
		return a == reg_addr;
	endfunction

	// ----------------------------------------------------------------
	// avalon slave handshake
	// ----------------------------------------------------------------
	// every access takes exactly one wait cycle; ack_ff drops waitrequest
	// for one cycle; reads capture on the edge that raises ack_ff, writes complete on the edge that ends it
	assign wr_go = avs_write && ack_ff;
	assign rd_go = avs_read && !ack_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			ack_ff <= 1'b0;
		else if ((avs_read || avs_write) && !ack_ff)
			ack_ff <= 1'b1;   // request seen, answer next edge
		else
			ack_ff <= 1'b0;   // answer given, back to waiting
	end

	// read data captured as waitrequest goes low, held while idle
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			rdata_ff <= 32'h0000_0000;
		else if (rd_go)
			rdata_ff <= rd_word;
	end

	// ----------------------------------------------------------------
	// read mux, unmapped addresses read as zero
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit(avs_address, scrc_pkg::ADDR_RUN_CLOCK_CONFIG))
			rd_word[7:0] = run_clock_config_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_RAW_STATUS))
			rd_word[3:0] = raw_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_INTERRUPT_MASK_CONTROL))
			rd_word[3:0] = interrupt_mask_control_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_MASKED_STATUS))
			rd_word[3:0] = raw_ff & interrupt_mask_control_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_DEEP_SLEEP_CLOCK_CONFIG))
			rd_word[1:0] = deep_sleep_clock_config_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_CRYSTAL_TO_PLL_TRANS))
			rd_word[13:0] = trans_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_REGULATOR_POWER_CONTROL))
			rd_word[2:0] = regulator_power_control_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_UNREGULATED_RESET_ALLOW))
			rd_word[0] = unregulated_reset_allow_ff;
		else if (hit(avs_address, scrc_pkg::ADDR_SYSTEM_STATUS))
			// live state: failover, lock, clock select, sequencer state
			rd_word[9:0] = {pll_locked_q_ff, failover_ff, wk.clk_sel,
				wk.core_run_en, 1'b0, wk.state};
		else
			rd_word = 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// run clock config and crystal translation
	// ----------------------------------------------------------------
	// register sits in byte 0; the cast drops the upper lanes
	assign rcc_wr = 8'(be_merge({24'h00_0000, run_clock_config_ff}, avs_writedata,
		avs_byteenable));

	// any reset powers the pll down and restores 6 mhz crystal
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			run_clock_config_ff <= scrc_pkg::RCC_RESET;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_RUN_CLOCK_CONFIG))
			run_clock_config_ff <= rcc_wr;
	end

	// translation tracks crystal on every reset and every write, so the
	// pll never sees a stale value after an external reset
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			trans_ff <= scrc_pkg::TRANS_6MHZ;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_RUN_CLOCK_CONFIG))
			// table targets 400 mhz for every supported crystal
			trans_ff <= scrc_pkg::crystal_freq_select_to_trans(
				rcc_wr[scrc_pkg::RCC_CRYSTAL_FREQ_SELECT_LSB +: scrc_pkg::CRYSTAL_FREQ_SELECT_W]);
	end

	// ----------------------------------------------------------------
	// plain configuration registers
	// ----------------------------------------------------------------
	// event masks, same layout as raw status
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			interrupt_mask_control_ff <= scrc_pkg::IMC_RESET;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_INTERRUPT_MASK_CONTROL))
			interrupt_mask_control_ff <= 4'(be_merge({28'h000_0000, interrupt_mask_control_ff},
				avs_writedata, avs_byteenable));
	end

	// deep sleep source selects which oscillator feeds sleep
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			deep_sleep_clock_config_ff <= scrc_pkg::CLK_MAIN_OSC;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_DEEP_SLEEP_CLOCK_CONFIG))
			deep_sleep_clock_config_ff <= 2'(be_merge({30'h0000_0000,
				deep_sleep_clock_config_ff}, avs_writedata, avs_byteenable));
	end

	// regulator level is software's job; we only hold and drive it
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			regulator_power_control_ff <= scrc_pkg::VADJ_RESET;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_REGULATOR_POWER_CONTROL))
			regulator_power_control_ff <= 3'(be_merge({29'h0000_0000,
				regulator_power_control_ff}, avs_writedata, avs_byteenable));
	end

	// escalation stays off after any reset
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			unregulated_reset_allow_ff <= 1'b0;
		else if (wr_go && hit(avs_address, scrc_pkg::ADDR_UNREGULATED_RESET_ALLOW))
			unregulated_reset_allow_ff <= 1'(be_merge({31'h0000_0000,
				unregulated_reset_allow_ff}, avs_writedata, avs_byteenable));
	end

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	// levels sampled each edge; pins are synchronous
	always_comb
	begin
		evt_set = 4'h0;
		// failure counts only while verification is enabled
		evt_set[scrc_pkg::EVT_OSC_FAIL] = main_osc_fail
			&& run_clock_config_ff[scrc_pkg::RCC_VERIFY_BIT];
		evt_set[scrc_pkg::EVT_CURRENT_LIMIT] = current_limit_evt;
		evt_set[scrc_pkg::EVT_UNREGULATED]   = unregulated_evt;
		// lock edge ignored while the pll is powered down
		evt_set[scrc_pkg::EVT_PLL_LOCK] = pll_locked && !pll_locked_q_ff
			&& !run_clock_config_ff[scrc_pkg::RCC_PLL_PLL_POWER_DOWN_BIT];
	end

	// clear only on the completing write edge
	assign evt_clr = (wr_go && hit(avs_address, scrc_pkg::ADDR_RAW_STATUS))
		? (avs_writedata[3:0] & {4{avs_byteenable[0]}}) : 4'h0;

	// set wins over clear so a same-cycle event is not lost
	assign nxt_raw = (raw_ff & ~evt_clr) | evt_set;

	// ----------------------------------------------------------------
	// sticky raw flags, independent of masks
	// ----------------------------------------------------------------
	// hardware sets, software writes one to clear
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			raw_ff <= 4'h0;
		else
			raw_ff <= nxt_raw;
	end

	// lock level one cycle ago, for edge detection
	// reset low is harmless: the pll is down then
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			pll_locked_q_ff <= 1'b0;
		else
			pll_locked_q_ff <= pll_locked;
	end

	// failover is sticky until reset; a flaky oscillator must not be
	// trusted again just because it restarted
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			failover_ff <= 1'b0;
		else if (evt_set[scrc_pkg::EVT_OSC_FAIL])
			failover_ff <= 1'b1;
	end

	// ----------------------------------------------------------------
	// interrupt and reset request
	// ----------------------------------------------------------------
	// masked or of the flags; a clear mask bit blocks that source
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(raw_ff & interrupt_mask_control_ff);
	end

	// unregulated power escalates to a system reset when allowed
	always_ff @(posedge sys_clk)
	begin
		if (rst_any)
			reset_req_ff <= 1'b0;
		else
			reset_req_ff <= unregulated_evt && unregulated_reset_allow_ff;
	end

	// ----------------------------------------------------------------
	// wake sequencer hookup
	// ----------------------------------------------------------------
	// sequencer inputs, plain wiring
	assign wk.failover       = failover_ff;
	assign wk.run_internal   = run_clock_config_ff[scrc_pkg::RCC_RUN_INT_BIT];
	assign wk.pll_active     = !run_clock_config_ff[scrc_pkg::RCC_PLL_PLL_POWER_DOWN_BIT]
		&& !run_clock_config_ff[scrc_pkg::RCC_PLL_BYPASS_BIT];
	assign wk.ds_source      = deep_sleep_clock_config_ff;
	assign wk.deep_sleep_req = deep_sleep_req;
	assign wk.wake_evt       = wake_evt;
	assign wk.osc_stable     = main_osc_stable;
	assign wk.pll_locked     = pll_locked;

	// same clock, and either reset source
	scrc_wake_seq u_wake
	(
		.sys_clk (sys_clk),
		.rst     (rst_any),
		.wk      (wk.seq)
	);

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = !ack_ff;
	assign irq             = irq_ff;
	assign sys_reset_req   = reset_req_ff;
	assign core_run_en     = wk.core_run_en;
	assign clk_sel         = wk.clk_sel;
	assign pll_power_down  = run_clock_config_ff[scrc_pkg::RCC_PLL_PLL_POWER_DOWN_BIT];
	assign pll_prediv      = trans_ff[scrc_pkg::MULT_W +: scrc_pkg::PREDIV_W];
	assign pll_mult        = trans_ff[scrc_pkg::MULT_W-1:0];
	assign regulator_vadj  = regulator_power_control_ff;

endmodule

// file: verilog/scrc_wake_if.sv
`timescale 1ns/100ps
// config and status between the register side and the wake sequencer
interface scrc_wake_if;
	logic       failover;        // main oscillator declared dead
	logic       run_internal;    // run mode source is internal 12 mhz
	logic       pll_active;      // pll powered and not bypassed
	logic [1:0] ds_source;       // deep_sleep_clock_source
	logic       deep_sleep_req;  // core asks for deep sleep
	logic       wake_evt;        // wake-up event
	logic       osc_stable;      // main oscillator stable
	logic       pll_locked;      // pll lock indication
	logic [1:0] clk_sel;         // selected core clock, registered
	logic       core_run_en;     // core may execute, registered
	logic [3:0] state;           // sequencer state for status readback

	modport ctrl (output failover, run_internal, pll_active, ds_source, deep_sleep_req,
		wake_evt, osc_stable, pll_locked, input clk_sel, core_run_en, state);
	modport seq (input failover, run_internal, pll_active, ds_source, deep_sleep_req,
		wake_evt, osc_stable, pll_locked, output clk_sel, core_run_en, state);
endinterface

// file: verilog/scrc_wake_seq.sv
`timescale 1ns/100ps
module scrc_wake_seq
(
	input  wire logic sys_clk,
	input  wire logic rst,
	scrc_wake_if.seq  wk
);

	scrc_pkg::scrc_wake_state_type state_ff;      // current state
	scrc_pkg::scrc_wake_state_type nxt_state;     // next state
	logic [1:0]                    run_sel;       // clock used in run mode
	logic [1:0]                    clk_sel_ff;    // registered clock select
	logic                          core_run_ff;   // registered run enable

	// failover forces the internal oscillator regardless of config
	assign run_sel = (wk.failover || wk.run_internal) ? scrc_pkg::CLK_INT_12M
		: scrc_pkg::CLK_MAIN_OSC;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			scrc_pkg::WAKE_RUN:
				if (wk.deep_sleep_req)
					nxt_state = scrc_pkg::WAKE_SLEEP;
			scrc_pkg::WAKE_SLEEP:
				// main osc source must settle before the core runs
				if (wk.wake_evt)
					nxt_state = (run_sel == scrc_pkg::CLK_MAIN_OSC)
						? scrc_pkg::WAKE_WAIT_OSC : scrc_pkg::WAKE_RUN;
			scrc_pkg::WAKE_WAIT_OSC:
				if (wk.failover)
					nxt_state = scrc_pkg::WAKE_RUN;
				else if (wk.osc_stable)
					// pll path switches only once the pll is ready
					nxt_state = wk.pll_active ? scrc_pkg::WAKE_WAIT_PLL
						: scrc_pkg::WAKE_RUN;
			scrc_pkg::WAKE_WAIT_PLL:
				if (wk.pll_locked || wk.failover)
					nxt_state = scrc_pkg::WAKE_RUN;
			default:
				nxt_state = scrc_pkg::WAKE_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_ff <= scrc_pkg::WAKE_RUN;
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------------------------------
	// clock select and core enable follow the next state
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			clk_sel_ff  <= scrc_pkg::CLK_MAIN_OSC;
			core_run_ff <= 1'b1;
		end
		else
		begin
			// run mode: main osc, or internal 12 mhz when run_internal is set or after a failure
			if (nxt_state == scrc_pkg::WAKE_RUN)
				clk_sel_ff <= run_sel;
			else
				clk_sel_ff <= wk.ds_source;   // deep sleep source
			core_run_ff <= (nxt_state == scrc_pkg::WAKE_RUN);
		end
	end

	assign wk.clk_sel     = clk_sel_ff;
	assign wk.core_run_en = core_run_ff;
	assign wk.state       = state_ff;

endmodule
